// *** design/reg_store.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_defs.svh"
module reg_store (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic [7:0] recovery_mode_control_o,
    output logic [7:0] acquisition_control_o,
    output logic [7:0] reference_buffer_control_o,
    output logic [7:0] reference_lock_config_o,
    output logic [7:0] output_driver_control_o
);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            recovery_mode_control_o <= `RST_RECOVERY_MODE;
            acquisition_control_o <= `RST_ACQUISITION;
            reference_buffer_control_o <= `RST_REF_BUFFER;
            reference_lock_config_o <= `RST_REF_LOCK_CFG;
            output_driver_control_o <= `RST_OUTPUT_DRIVER;
        end else if (ce_i && wr_i) begin
            case (addr_i)
                `OFS_RECOVERY_MODE: recovery_mode_control_o <= wdata_i;
                `OFS_ACQUISITION: acquisition_control_o <= wdata_i;
                `OFS_REF_BUFFER: reference_buffer_control_o <= wdata_i;
                `OFS_REF_LOCK_CFG: reference_lock_config_o <= wdata_i;
                `OFS_OUTPUT_DRIVER: output_driver_control_o <= wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            case (addr_i)
                `OFS_RECOVERY_MODE: rdata_o <= recovery_mode_control_o;
                `OFS_ACQUISITION: rdata_o <= acquisition_control_o;
                `OFS_REF_BUFFER: rdata_o <= reference_buffer_control_o;
                `OFS_REF_LOCK_CFG: rdata_o <= reference_lock_config_o;
                `OFS_OUTPUT_DRIVER: rdata_o <= output_driver_control_o;
                default: rdata_o <= 8'h00;
            endcase
        end
    end
endmodule : reg_store
`default_nettype wire

// *** design/serial_config_and_ref_lock_control.sv ***
// Overview of operation
// R01: Output power-down bit fully powers down the serial data output pair.
// R02: Squelch keeps driver on, forcing data to the squelch level bit.
// R03: Slave address is 100000 plus the address select pin.
// R04: Eighth bit after address: 1 read, 0 write.
// R05: Start is data falling while clock high.
// R06: Address byte shifts in MSB first, eight bits.
// R07: Matching address is acknowledged by pulling data low on ninth pulse.
// R08: Mismatched address releases bus and waits for next start.
// R09: First byte is address, second is starting subaddress.
// R10: Further bytes auto-increment the register; stop ends transfer.
// R11: Start or stop at any point returns to idle or restarts.
// R12: Master issues at most one start, one stop, or stop-start per clock high.
// R13: Invalid subaddress gets no acknowledge and returns to idle.
// R14: Reads past the top repeat the highest register until no acknowledge.
// R15: Mode field 2 selects lock to reference; buffer enabled by pdn bit 0.
// R16: Software must not combine rate measurement with lock to reference.
// R17: Lock where data/2^(ratio-1) equals reference/2^band.
// R18: Band field selects one of four reference octaves, default lowest.
// R19: Ratio field n selects ratio two to the n minus one.
// R20: After band or ratio changes, software pulses restart acquisition.
// R21: Tracking compares oscillator to reference; over 1000 ppm asserts lock lost.
// R22: Loss-of-lock source bit 1 compares against data frequency instead.
// R23: Lock lost clears only within 250 ppm, giving hysteresis.
// R24: Harmonic detector disabled in lock to reference mode.
// R25: Bus lines are synchronised and edge detected with the internal clock.
// R26: Restart acquisition fires once on the falling edge of its bit.
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_defs.svh"
module serial_config_and_ref_lock_control (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic addr_sel_i,
    input wire logic recovered_data_i,
    input wire logic ref_freq_err_ok_i,
    input wire logic ref_freq_err_bad_i,
    input wire logic data_freq_err_ok_i,
    input wire logic data_freq_err_bad_i,
    output logic serial_data_out_o,
    output logic data_out_powerdown_o,
    output logic lock_to_reference_o,
    output logic ref_buffer_powerdown_o,
    output logic rate_measure_enable_o,
    output logic [1:0] ref_band_field_o,
    output logic [3:0] rate_ratio_field_o,
    output logic lol_data_source_o,
    output logic restart_acquisition_o,
    output logic lock_lost_o,
    output logic harmonic_detect_enable_o
);
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] addr_sel_sync;
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    serial_cfg_pkg::bus_state_type state;
    serial_cfg_pkg::bus_state_type after_ack;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] subaddr;
    logic reg_wr;
    logic [7:0] rdata;
    logic ack_ok;
    logic [7:0] recovery_mode_control;
    logic [7:0] acquisition_control;
    logic [7:0] reference_buffer_control;
    logic [7:0] reference_lock_config;
    logic [7:0] output_driver_control;
    logic restart_prev;
    logic in_ltr;
    logic err_bad;
    logic err_ok;

    function automatic logic valid_subaddr(input logic [7:0] a);
        valid_subaddr = (a == `OFS_RECOVERY_MODE) || (a == `OFS_ACQUISITION) ||
            (a == `OFS_REF_BUFFER) || (a == `OFS_REF_LOCK_CFG) ||
            (a == `OFS_OUTPUT_DRIVER);
    endfunction : valid_subaddr

    // Two-flop synchronisers; edges come from the second stage only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            addr_sel_sync <= 2'h0;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else if (ce_i) begin
            scl_sync <= {scl_sync[0], scl_i}; // R25
            sda_sync <= {sda_sync[0], sda_i}; // R25
            addr_sel_sync <= {addr_sel_sync[0], addr_sel_i}; // R25
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    assign scl_rise = scl_sync[1] && !scl_prev;
    assign scl_fall = !scl_sync[1] && scl_prev;
    assign start_seen = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1]; // R05
    assign stop_seen = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= serial_cfg_pkg::ST_IDLE;
            after_ack <= serial_cfg_pkg::ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            subaddr <= 8'h00;
            reg_wr <= 1'b0;
            ack_ok <= 1'b0;
            sda_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            reg_wr <= 1'b0;
            if (start_seen) begin
                state <= serial_cfg_pkg::ST_ADDR; // R11
                bit_cnt <= 4'h0;
                sda_oe_n_o <= 1'b1;
            end else if (stop_seen) begin
                state <= serial_cfg_pkg::ST_IDLE; // R11
                sda_oe_n_o <= 1'b1;
            end else begin
                case (state)
                    serial_cfg_pkg::ST_IDLE: sda_oe_n_o <= 1'b1; // R08
                    serial_cfg_pkg::ST_ADDR, serial_cfg_pkg::ST_SUBADDR,
                    serial_cfg_pkg::ST_WRITE: begin
                        if (scl_rise && bit_cnt < 4'h8) begin
                            shift <= {shift[6:0], sda_sync[1]}; // R06
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            state <= serial_cfg_pkg::ST_ACK;
                            ack_ok <= 1'b0;
                            if (state == serial_cfg_pkg::ST_ADDR) begin
                                if (shift[7:1] == {`SLAVE_ADDR_HI, addr_sel_sync[1]}) begin // R03
                                    ack_ok <= 1'b1;
                                    sda_o <= 1'b0; // R07
                                    sda_oe_n_o <= 1'b0;
                                    after_ack <= shift[0] ? serial_cfg_pkg::ST_READ
                                        : serial_cfg_pkg::ST_SUBADDR; // R04
                                end else begin
                                    state <= serial_cfg_pkg::ST_IDLE; // R08
                                end
                            end else if (state == serial_cfg_pkg::ST_SUBADDR) begin
                                if (valid_subaddr(shift)) begin // R09
                                    subaddr <= shift;
                                    ack_ok <= 1'b1;
                                    sda_o <= 1'b0;
                                    sda_oe_n_o <= 1'b0;
                                    after_ack <= serial_cfg_pkg::ST_WRITE;
                                end else begin
                                    state <= serial_cfg_pkg::ST_IDLE; // R13
                                end
                            end else begin
                                reg_wr <= 1'b1; // R10
                                sda_o <= 1'b0;
                                sda_oe_n_o <= 1'b0;
                                ack_ok <= 1'b1;
                                after_ack <= serial_cfg_pkg::ST_WRITE;
                            end
                        end
                    end
                    serial_cfg_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            sda_oe_n_o <= 1'b1;
                            if (after_ack == serial_cfg_pkg::ST_READ) begin
                                sda_o <= rdata[7];
                                sda_oe_n_o <= !ack_ok;
                                shift <= {rdata[6:0], 1'b0};
                                bit_cnt <= 4'h1;
                            end
                            state <= after_ack;
                        end
                    end
                    serial_cfg_pkg::ST_READ: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                sda_oe_n_o <= 1'b1;
                                state <= serial_cfg_pkg::ST_READ_ACK;
                                if (subaddr < `OFS_HIGHEST) begin
                                    subaddr <= subaddr + 8'h01; // R14
                                end
                            end else begin
                                sda_o <= shift[7]; // R06
                                shift <= {shift[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    serial_cfg_pkg::ST_READ_ACK: begin
                        if (scl_rise) begin
                            if (sda_sync[1]) begin
                                state <= serial_cfg_pkg::ST_IDLE; // R14
                            end else begin
                                ack_ok <= 1'b1;
                                after_ack <= serial_cfg_pkg::ST_READ;
                                state <= serial_cfg_pkg::ST_ACK;
                            end
                        end
                    end
                    default: state <= serial_cfg_pkg::ST_IDLE;
                endcase
            end
            if (reg_wr && subaddr < `OFS_HIGHEST) begin
                subaddr <= subaddr + 8'h01; // R10
            end
        end
    end

    reg_store u_reg_store (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .wr_i(reg_wr),
        .addr_i(subaddr),
        .wdata_i(shift),
        .rdata_o(rdata),
        .recovery_mode_control_o(recovery_mode_control),
        .acquisition_control_o(acquisition_control),
        .reference_buffer_control_o(reference_buffer_control),
        .reference_lock_config_o(reference_lock_config),
        .output_driver_control_o(output_driver_control)
    );

    assign in_ltr = recovery_mode_control[`POS_MODE_HI:`POS_MODE_LO] == `MODE_LOCK_TO_REF;
    assign err_bad = reference_lock_config[`POS_LOL_SRC] ? data_freq_err_bad_i
        : ref_freq_err_bad_i; // R22
    assign err_ok = reference_lock_config[`POS_LOL_SRC] ? data_freq_err_ok_i
        : ref_freq_err_ok_i; // R21

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            serial_data_out_o <= 1'b0;
            data_out_powerdown_o <= 1'b0;
        end else if (ce_i) begin
            data_out_powerdown_o <= output_driver_control[`POS_OUT_PDN]; // R01
            if (output_driver_control[`POS_SQUELCH]) begin
                serial_data_out_o <= output_driver_control[`POS_SQUELCH_LVL]; // R02
            end else begin
                serial_data_out_o <= recovered_data_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock_to_reference_o <= 1'b0;
            ref_buffer_powerdown_o <= 1'b1;
            rate_measure_enable_o <= 1'b0;
            ref_band_field_o <= 2'h0;
            rate_ratio_field_o <= 4'h0;
            lol_data_source_o <= 1'b0;
            harmonic_detect_enable_o <= 1'b1;
        end else if (ce_i) begin
            lock_to_reference_o <= in_ltr; // R15
            ref_buffer_powerdown_o <= reference_buffer_control[`POS_REF_PDN]; // R15
            rate_measure_enable_o <= recovery_mode_control[`POS_RATE_MEASURE_ENABLE];
            ref_band_field_o <= reference_lock_config[`POS_BAND_HI:`POS_BAND_LO]; // R18
            rate_ratio_field_o <= reference_lock_config[`POS_RATIO_HI:`POS_RATIO_LO]; // R17 R19
            lol_data_source_o <= reference_lock_config[`POS_LOL_SRC];
            harmonic_detect_enable_o <= !in_ltr; // R24
        end
    end

    // Restart pulse on the 1-to-0 transition of the bit
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            restart_prev <= 1'b0;
            restart_acquisition_o <= 1'b0;
        end else if (ce_i) begin
            restart_prev <= acquisition_control[`POS_RESTART_ACQ];
            restart_acquisition_o <= restart_prev &&
                !acquisition_control[`POS_RESTART_ACQ]; // R26
        end
    end

    // Hysteresis: set above 1000 ppm, clear within 250 ppm
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock_lost_o <= 1'b1;
        end else if (ce_i) begin
            if (restart_acquisition_o) begin
                lock_lost_o <= 1'b1;
            end else if (err_bad) begin
                lock_lost_o <= 1'b1; // R21
            end else if (err_ok) begin
                lock_lost_o <= 1'b0; // R23
            end
        end
    end
endmodule : serial_config_and_ref_lock_control
`default_nettype wire

// *** inc/serial_cfg_defs.svh ***
`ifndef SERIAL_CFG_DEFS_SVH
`define SERIAL_CFG_DEFS_SVH

// Slave address upper six bits
`define SLAVE_ADDR_HI 6'h20
// Register offsets
`define OFS_RECOVERY_MODE 8'h08
`define OFS_ACQUISITION 8'h09
`define OFS_REF_BUFFER 8'h0A
`define OFS_REF_LOCK_CFG 8'h0F
`define OFS_OUTPUT_DRIVER 8'h1E
`define OFS_HIGHEST 8'h1E
// Field positions
`define POS_RATE_MEASURE_ENABLE 1
`define POS_MODE_LO 4
`define POS_MODE_HI 6
`define POS_RESTART_ACQ 6
`define POS_REF_PDN 2
`define POS_RATIO_LO 0
`define POS_RATIO_HI 3
`define POS_BAND_LO 4
`define POS_BAND_HI 5
`define POS_LOL_SRC 6
`define POS_SQUELCH_LVL 1
`define POS_OUT_PDN 4
`define POS_SQUELCH 5
// Reset values
`define RST_RECOVERY_MODE 8'h00
`define RST_ACQUISITION 8'h00
`define RST_REF_BUFFER 8'h05
`define RST_REF_LOCK_CFG 8'h00
`define RST_OUTPUT_DRIVER 8'h00
// Mode encoding
`define MODE_LOCK_TO_REF 3'h2
// Frequency error thresholds in ppm
`define PPM_ASSERT 1000
`define PPM_RELEASE 250

`endif

// *** inc/serial_cfg_pkg.sv ***
package serial_cfg_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SUBADDR,
        ST_WRITE,
        ST_READ,
        ST_ACK,
        ST_READ_ACK
    } bus_state_type;
endpackage : serial_cfg_pkg

// *** test/bus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    localparam int HALF = 20;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge clk_i);
    endtask : pause
    task automatic start_cond();
        sda_o = 1'b1;
        pause(HALF);
        scl_o = 1'b1;
        pause(HALF);
        sda_o = 1'b0;
        pause(HALF);
        scl_o = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        pause(HALF / 2);
        sda_o = 1'b0;
        pause(HALF);
        scl_o = 1'b1;
        pause(HALF);
        sda_o = 1'b1;
        pause(HALF);
    endtask : stop_cond
    task automatic put_bit(input logic b, output logic s);
        pause(HALF / 2);
        sda_o = b;
        pause(HALF / 2);
        scl_o = 1'b1;
        pause(HALF / 2);
        s = sda_i;
        pause(HALF / 2);
        scl_o = 1'b0;
    endtask : put_bit
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        acked = ~s;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(last, s);
    endtask : recv_byte
endmodule : bus_master_model
`default_nettype wire

// *** test/serial_cfg_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_cfg_checker (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe_n_o,
    input wire logic ref_freq_err_ok_i,
    input wire logic ref_freq_err_bad_i,
    input wire logic data_freq_err_ok_i,
    input wire logic data_freq_err_bad_i,
    input wire logic lock_to_reference_o,
    input wire logic lol_data_source_o,
    input wire logic [1:0] ref_band_field_o,
    input wire logic restart_acquisition_o,
    input wire logic lock_lost_o,
    input wire logic harmonic_detect_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_restart_one_cycle: assert property (restart_acquisition_o |=> !restart_acquisition_o)
        else $error("restart pulse longer than one cycle");
    a_restart_sets_lol: assert property (restart_acquisition_o |-> ##[1:3] lock_lost_o)
        else $error("restart did not raise lock lost");
    a_ref_bad_lol: assert property ((lock_to_reference_o && !lol_data_source_o && ref_freq_err_bad_i) [*4] |-> lock_lost_o)
        else $error("reference error did not raise lock lost");
    a_data_bad_lol: assert property ((lock_to_reference_o && lol_data_source_o && data_freq_err_bad_i) [*4] |-> lock_lost_o)
        else $error("data error did not raise lock lost");
    a_lol_clear_ok: assert property ($fell(lock_lost_o) |-> $past(ref_freq_err_ok_i | data_freq_err_ok_i, 1) || $past(ref_freq_err_ok_i | data_freq_err_ok_i, 2) || $past(ref_freq_err_ok_i | data_freq_err_ok_i, 3))
        else $error("lock lost cleared without frequency within band");
    a_harm_off_ltr: assert property ($stable(lock_to_reference_o) [*3] |-> harmonic_detect_enable_o != lock_to_reference_o)
        else $error("harmonic detector state wrong for mode");
    a_drive_scl_low: assert property ($fell(sda_oe_n_o) |-> !scl_i)
        else $error("data line taken while clock high");
    a_release_scl_low: assert property ($rose(sda_oe_n_o) |-> !scl_i)
        else $error("data line released while clock high");
    a_band_quiet: assert property ((scl_i && sda_i) [*8] |=> $stable(ref_band_field_o))
        else $error("band field changed on idle bus");
endmodule : serial_cfg_checker
bind serial_config_and_ref_lock_control serial_cfg_checker i_chk (.clk_i, .srst_i, .scl_i, .sda_i,
    .sda_oe_n_o, .ref_freq_err_ok_i, .ref_freq_err_bad_i, .data_freq_err_ok_i, .data_freq_err_bad_i,
    .lock_to_reference_o, .lol_data_source_o, .ref_band_field_o, .restart_acquisition_o,
    .lock_lost_o, .harmonic_detect_enable_o);
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "serial_cfg_defs.svh"
module testbench;
    logic clk_i, srst_i, ce_i, addr_sel_i, recovered_data_i, m_scl, m_sda;
    logic ref_freq_err_ok_i, ref_freq_err_bad_i, data_freq_err_ok_i, data_freq_err_bad_i;
    logic sda_o, sda_oe_n_o, serial_data_out_o, data_out_powerdown_o, lock_to_reference_o;
    logic ref_buffer_powerdown_o, rate_measure_enable_o, lol_data_source_o;
    logic restart_acquisition_o, lock_lost_o, harmonic_detect_enable_o;
    logic [1:0] ref_band_field_o;
    logic [3:0] rate_ratio_field_o;
    wire logic sda_bus;
    int fail_count = 0;
    int compares = 0;
    int pulse_cnt = 0;
    int model[int];
    // Open-drain data line with pull-up
    assign sda_bus = m_sda & (sda_oe_n_o | sda_o);
    serial_config_and_ref_lock_control i_serial_config_and_ref_lock_control (.clk_i, .srst_i,
        .ce_i, .scl_i(m_scl), .sda_i(sda_bus), .sda_o, .sda_oe_n_o, .addr_sel_i,
        .recovered_data_i, .ref_freq_err_ok_i, .ref_freq_err_bad_i, .data_freq_err_ok_i,
        .data_freq_err_bad_i, .serial_data_out_o, .data_out_powerdown_o, .lock_to_reference_o,
        .ref_buffer_powerdown_o, .rate_measure_enable_o, .ref_band_field_o, .rate_ratio_field_o,
        .lol_data_source_o, .restart_acquisition_o, .lock_lost_o, .harmonic_detect_enable_o);
    bus_master_model i_master (.clk_i, .sda_i(sda_bus), .scl_o(m_scl), .sda_o(m_sda));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(negedge clk_i) if (restart_acquisition_o === 1'b1) pulse_cnt++;
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic chk_cfg();
        int lock_to_reference;
        lock_to_reference = ((model[8'h08] >> 4) & 7) == 2;
        check({6'h00, ref_band_field_o}, 8'((model[8'h0F] >> 4) & 3));
        check({4'h0, rate_ratio_field_o}, 8'(model[8'h0F] & 15));
        check({7'h00, lol_data_source_o}, 8'((model[8'h0F] >> 6) & 1));
        check({7'h00, lock_to_reference_o}, 8'(lock_to_reference));
        check({7'h00, harmonic_detect_enable_o}, 8'(!lock_to_reference));
        check({7'h00, ref_buffer_powerdown_o}, 8'((model[8'h0A] >> 2) & 1));
        check({7'h00, rate_measure_enable_o}, 8'((model[8'h08] >> 1) & 1));
        check({7'h00, data_out_powerdown_o}, 8'((model[8'h1E] >> 4) & 1));
    endtask : chk_cfg
    task automatic begin_xfer(input logic [7:0] sub);
        logic a;
        i_master.start_cond();
        i_master.send_byte({`SLAVE_ADDR_HI, addr_sel_i, 1'b0}, a);
        check({7'h00, a}, 8'h01);
        i_master.send_byte(sub, a);
        check({7'h00, a}, 8'(model.exists(sub)));
    endtask : begin_xfer
    task automatic wr_seq(input logic [7:0] sub, input logic [7:0] d[$]);
        logic a;
        begin_xfer(sub);
        foreach (d[i]) begin
            i_master.send_byte(d[i], a);
            if (model.exists(sub + i)) model[sub + i] = d[i];
        end
        i_master.stop_cond();
        repeat (4) @(negedge clk_i);
    endtask : wr_seq
    task automatic rd_seq(input logic [7:0] sub, input int n);
        logic [7:0] b;
        int k;
        begin_xfer(sub);
        i_master.stop_cond();
        i_master.start_cond();
        i_master.send_byte({`SLAVE_ADDR_HI, addr_sel_i, 1'b1}, b[0]);
        check({7'h00, b[0]}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_master.recv_byte(b, i == n - 1);
            k = (sub + i > `OFS_HIGHEST) ? `OFS_HIGHEST : sub + i;
            check(b, model.exists(k) ? 8'(model[k]) : 8'h00);
        end
        i_master.stop_cond();
    endtask : rd_seq
    initial begin
        repeat (90000) @(posedge clk_i);
        fail_count++;
        test_done();
    end
    initial begin
        logic [7:0] q[$];
        static logic [7:0] sq[4] = '{8'h00, 8'h20, 8'h22, 8'h10};
        static logic [4:0] lt[12] = '{5'h10, 5'h00, 5'h02, 5'h09, 5'h01, 5'h05, 5'h10,
            5'h04, 5'h08, 5'h03, 5'h11, 5'h04};
        logic a;
        srst_i = 1'b1;
        ce_i = 1'b1;
        addr_sel_i = 1'b0;
        recovered_data_i = 1'b0;
        {ref_freq_err_ok_i, ref_freq_err_bad_i, data_freq_err_ok_i, data_freq_err_bad_i} = 4'h0;
        void'($urandom(32'h01DD));
        model[8'h08] = `RST_RECOVERY_MODE;
        model[8'h09] = `RST_ACQUISITION;
        model[8'h0A] = `RST_REF_BUFFER;
        model[8'h0F] = `RST_REF_LOCK_CFG;
        model[8'h1E] = `RST_OUTPUT_DRIVER;
        repeat (12) @(negedge clk_i);
        srst_i = 1'b0;
        check({7'h00, lock_lost_o}, 8'h01);
        check({7'h00, sda_oe_n_o}, 8'h01);
        chk_cfg();
        rd_seq(8'h08, 24);
        repeat (2) begin
            q = {};
            repeat (8) q.push_back(8'($urandom));
            if (q[0][6:4] == 3'h2) q[0][1] = 1'b0;
            wr_seq(8'h08, q);
            q = {};
            q.push_back(8'($urandom));
            wr_seq(8'h1E, q);
            chk_cfg();
            rd_seq(8'h0F, 18);
            rd_seq(8'h08, 3);
        end
        for (int s = 0; s < 2; s++) begin
            addr_sel_i = s[0];
            i_master.start_cond();
            i_master.send_byte({`SLAVE_ADDR_HI, ~addr_sel_i, 1'b0}, a);
            check({7'h00, a}, 8'h00);
            i_master.stop_cond();
            rd_seq(8'h0A, 1);
        end
        q = {};
        wr_seq(8'h10, q);
        wr_seq(8'h0B, q);
        foreach (sq[j]) begin
            q = {};
            q.push_back(sq[j]);
            wr_seq(8'h1E, q);
            chk_cfg();
            if (!sq[j][4]) repeat (6) begin
                recovered_data_i = 1'($urandom);
                repeat (3) @(negedge clk_i);
                check({7'h00, serial_data_out_o}, {7'h00, sq[j][5] ? sq[j][1] : recovered_data_i});
            end
        end
        q = '{8'h20, 8'h00, 8'h01};
        wr_seq(8'h08, q);
        chk_cfg();
        pulse_cnt = 0;
        q = '{8'h40};
        wr_seq(8'h09, q);
        check(8'(pulse_cnt), 8'h00);
        q[0] = 8'h00;
        wr_seq(8'h09, q);
        repeat (10) @(negedge clk_i);
        check(8'(pulse_cnt), 8'h01);
        wr_seq(8'h0F, q);
        // Clock enable low must freeze lock lost despite a good frequency
        ce_i = 1'b0;
        ref_freq_err_ok_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check({7'h00, lock_lost_o}, 8'h01);
        ce_i = 1'b1;
        foreach (lt[i]) begin
            if (i == 7) begin
                q[0] = 8'h40;
                wr_seq(8'h0F, q);
            end
            {ref_freq_err_ok_i, ref_freq_err_bad_i, data_freq_err_ok_i, data_freq_err_bad_i} = lt[i][4:1];
            repeat (6) @(negedge clk_i);
            check({7'h00, lock_lost_o}, {7'h00, lt[i][0]});
        end
        test_done();
    end
endmodule : testbench
`default_nettype wire
